// File: dai_pkg.sv
// constants shared by the dram addressing and power-up init block
// assumes a 40 MHz system clock and a classic wishbone register port
package dai_pkg;
  // geometry
  localparam int NUM_BANKS = 8;
  localparam int BA_W = 3;
  localparam int ADDR_W = 15;
  localparam int COL_W = 11;
  localparam int PAGE_BYTES = 1024;
  localparam int BURST_LEN = 8;
  localparam int CHOP_LEN = 4;
  // address bit positions
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int X4_COLHI_BIT = 11;
  localparam int DLL_EN_BIT = 0;
  localparam int DLL_RST_BIT = 8;
  localparam int BT_BIT = 3;
  // mode register selection by bank address
  localparam logic [2:0] MR0_SEL = 3'h0;
  localparam logic [2:0] MR1_SEL = 3'h1;
  localparam logic [2:0] MR2_SEL = 3'h2;
  localparam logic [2:0] MR3_SEL = 3'h3;
  // burst length field of MR0
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  // command codes {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_ZQ = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;
  // timing
  localparam int CLK_MHZ = 40;
  localparam int T_INIT_US = 500;
  localparam int INIT_CYC = T_INIT_US * CLK_MHZ;
  localparam int INIT_CNT_W = 20;
  // register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_MR0 = 5'h08;
  localparam logic [4:0] REG_MR1 = 5'h0c;
  localparam logic [4:0] REG_MR2 = 5'h10;
  localparam logic [4:0] REG_MR3 = 5'h14;
  localparam logic [4:0] REG_ROW = 5'h18;
  localparam logic [4:0] REG_LAST = 5'h1c;
  // control and status fields and resets
  localparam int CTRL_X8_BIT = 0;
  localparam logic CTRL_X8_RST = 1'b0;
  localparam int ST_ERR_BIT = 20;
  localparam int ST_SEQ_BIT = 12;
  localparam int ST_OPEN_BIT = 4;
  // power-up state, one-hot
  typedef enum logic [3:0] {
    DAI_RESET = 4'h1,
    DAI_SELFINIT = 4'h2,
    DAI_WAIT_CKE = 4'h4,
    DAI_READY = 4'h8
  } dai_state_t;
endpackage

// File: dai_sync.sv
// two-flop synchroniser for a bundle of pin inputs
// assumes pins are asynchronous to clk_i; resets to a given pattern
`timescale 1ns/1ps
`default_nettype none
module dai_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic ce_i, // clock enable
  input wire logic [W-1:0] d_i, // asynchronous pins
  output logic [W-1:0] q_o // synchronised copy
);
  logic [W-1:0] meta;

  // ----------------------------------------------------------------
  // per-bit double flop
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // first stage feeds only the second stage
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta[g] <= RST_VAL[g];
          q_o[g] <= RST_VAL[g];
        end else if (ce_i) begin
          meta[g] <= d_i[g];
          q_o[g] <= meta[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// File: dai_top.sv
// dram device front end: addressing, burst sequencing, power-up init
// assumes link pins asynchronous to clk_i and a classic wishbone master
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dai_top
  import dai_pkg::*;
#(
  parameter int INIT_CYCLES = dai_pkg::INIT_CYC
) (
  input wire logic clk_i, // 40 MHz system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic ce_i, // clock enable, freezes state when low
  // link pins from the controller
  input wire logic ck_i, // link clock
  input wire logic cke_i, // link clock enable
  input wire logic cs_n_i, // chip select, active low
  input wire logic ras_n_i, // row strobe, active low
  input wire logic cas_n_i, // column strobe, active low
  input wire logic we_n_i, // write enable, active low
  input wire logic [dai_pkg::BA_W-1:0] ba_i, // bank address
  input wire logic [dai_pkg::ADDR_W-1:0] addr_i, // row/column/opcode
  input wire logic odt_i, // termination request
  input wire logic reset_n_i, // device reset, active low
  // device side results
  output logic term_en_o, // termination applied
  output logic [dai_pkg::BA_W-1:0] beat_bank_o, // bank of current beat
  output logic [dai_pkg::COL_W-1:0] beat_col_o, // column of current beat
  output logic beat_valid_o, // one pulse per half link clock beat
  output logic beat_wr_o, // current burst is a write
  output logic core_xfer_o, // pulse: one 8n word moved in the core
  output logic dll_reset_o, // pulse: dll reset requested
  output logic ready_o, // init done, cke registered
  // wishbone slave
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [4:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o // acknowledge
);
  localparam int PIN_W = 7 + BA_W + ADDR_W;
  localparam logic [PIN_W-1:0] PIN_RST = {3'h7, 1'b1, 1'b0, 1'b0, 1'b0,
                                          {BA_W{1'b0}}, {ADDR_W{1'b0}}};

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pins_s;
  logic cs_n_s, ck_s, cke_s, odt_s, reset_n_s;
  logic [2:0] cmd_s;
  logic [BA_W-1:0] ba_s;
  logic [ADDR_W-1:0] addr_s;

  dai_sync #(.W(PIN_W), .RST_VAL(PIN_RST)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({ras_n_i, cas_n_i, we_n_i, cs_n_i, ck_i, cke_i, odt_i, ba_i, addr_i}),
    .q_o(pins_s)
  );
  assign {cmd_s, cs_n_s, ck_s, cke_s, odt_s, ba_s, addr_s} = pins_s;

  // reset pin rides its own synchroniser and reads low after rst_i, so
  // the device stays in reset until the pin is really seen high
  dai_sync #(.W(1), .RST_VAL(1'b0)) u_rsync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(reset_n_i),
    .q_o(reset_n_s)
  );

  // ----------------------------------------------------------------
  // link clock edges
  // ----------------------------------------------------------------
  logic ck_q;
  logic ck_rise, ck_fall;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ck_q <= 1'b0;
    end else if (ce_i) begin
      ck_q <= ck_s;
    end
  end
  assign ck_rise = ck_s & ~ck_q;
  assign ck_fall = ~ck_s & ck_q;

  // ----------------------------------------------------------------
  // power-up state machine
  // ----------------------------------------------------------------
  dai_state_t state, next_state;
  logic [INIT_CNT_W-1:0] init_cnt;
  logic init_done;

  assign init_done = (init_cnt == INIT_CNT_W'(INIT_CYCLES - 1));

  // internal init runs off clk_i, not the link clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_cnt <= '0;
    end else if (ce_i) begin
      if (state != DAI_SELFINIT) begin
        init_cnt <= '0;
      end else if (!init_done) begin
        init_cnt <= init_cnt + 1'b1;
      end
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      DAI_RESET: begin
        next_state = DAI_SELFINIT;
      end
      DAI_SELFINIT: begin
        if (init_done) begin
          next_state = DAI_WAIT_CKE;
        end
      end
      DAI_WAIT_CKE: begin
        if (ck_rise && cke_s) begin
          next_state = DAI_READY; // cke registered high
        end
      end
      DAI_READY: begin
        next_state = DAI_READY;
      end
      default: begin
        next_state = DAI_RESET;
      end
    endcase
    // the reset pin acts at any time, warm or cold
    if (!reset_n_s) begin
      next_state = DAI_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= DAI_RESET;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  assign ready_o = (state == DAI_READY);

  // termination held off until cke is registered high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      term_en_o <= 1'b0;
    end else if (ce_i) begin
      term_en_o <= (state == DAI_READY) && reset_n_s && odt_s;
    end
  end

  // ----------------------------------------------------------------
  // command decode at the link clock rising edge
  // ----------------------------------------------------------------
  logic cmd_ok;
  logic is_act, is_rd, is_wr, is_pre, is_mrs;

  // only ready devices with cke high take commands
  assign cmd_ok = ck_rise && ready_o && cke_s && !cs_n_s;
  assign is_act = cmd_ok && (cmd_s == CMD_ACT);
  assign is_rd = cmd_ok && (cmd_s == CMD_RD);
  assign is_wr = cmd_ok && (cmd_s == CMD_WR);
  assign is_pre = cmd_ok && (cmd_s == CMD_PRE);
  assign is_mrs = cmd_ok && (cmd_s == CMD_MRS);

  // ----------------------------------------------------------------
  // mode registers, selected by bank address
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] mr [4];
  logic [3:0] mr_seen;
  logic zq_seen;

  always_ff @(posedge clk_i) begin
    if (rst_i || !reset_n_s) begin
      for (int i = 0; i < 4; i++) begin
        mr[i] <= '0;
      end
      mr_seen <= '0;
    end else if (ce_i && is_mrs && !ba_s[2]) begin
      mr[ba_s[1:0]] <= addr_s;
      mr_seen[ba_s[1:0]] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !reset_n_s) begin
      zq_seen <= 1'b0;
    end else if (ce_i && cmd_ok && cmd_s == CMD_ZQ && addr_s[AP_BIT]) begin
      zq_seen <= 1'b1; // long calibration seen
    end
  end

  // dll reset pulses on an MR0 load with A8 high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dll_reset_o <= 1'b0;
    end else if (ce_i) begin
      dll_reset_o <= is_mrs && (ba_s == MR0_SEL) && addr_s[DLL_RST_BIT];
    end
  end

  // ----------------------------------------------------------------
  // bank state: open flag and row per bank
  // ----------------------------------------------------------------
  logic [NUM_BANKS-1:0] bank_open;
  logic [ADDR_W-1:0] bank_row [NUM_BANKS];
  logic ap_close;
  logic [BA_W-1:0] burst_bank;
  logic burst_ap;

  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b++) begin : g_bank
      // activate opens, precharge or auto precharge closes
      always_ff @(posedge clk_i) begin
        if (rst_i || !reset_n_s) begin
          bank_open[b] <= 1'b0;
          bank_row[b] <= '0;
        end else if (ce_i) begin
          if (is_act && ba_s == BA_W'(b)) begin
            bank_open[b] <= 1'b1;
            bank_row[b] <= addr_s;
          end else if (is_pre && (addr_s[AP_BIT] || ba_s == BA_W'(b))) begin
            bank_open[b] <= 1'b0;
          end else if (ap_close && burst_bank == BA_W'(b)) begin
            bank_open[b] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // burst sequencer: beats on both link clock edges
  // ----------------------------------------------------------------
  logic ctrl_x8;
  logic burst_on, burst_chop;
  logic [2:0] beat_idx;
  logic [COL_W-1:0] start_col;
  logic [COL_W-1:0] cmd_col;
  logic cmd_chop;
  logic interleave;
  logic [2:0] ord;
  logic last_beat;
  logic bad_access;

  // x8 parts have no A11 column bit; 1KB page either way
  assign cmd_col = ctrl_x8 ? {1'b0, addr_s[9:0]}
                           : {addr_s[X4_COLHI_BIT], addr_s[9:0]};
  // fixed chop, or on-the-fly via A12 low
  assign cmd_chop = (mr[0][1:0] == BL_FIXED4) ||
                    ((mr[0][1:0] == BL_OTF) && !addr_s[BC_BIT]);
  assign interleave = mr[0][BT_BIT];
  assign bad_access = (is_rd || is_wr) && !bank_open[ba_s];
  assign last_beat = burst_chop ? (beat_idx == 3'(CHOP_LEN - 1))
                                : (beat_idx == 3'(BURST_LEN - 1));
  assign ap_close = burst_on && burst_ap && last_beat && (ck_rise || ck_fall);

  // start a burst on read/write to an open bank
  always_ff @(posedge clk_i) begin
    if (rst_i || !reset_n_s) begin
      burst_on <= 1'b0;
      burst_chop <= 1'b0;
      burst_ap <= 1'b0;
      burst_bank <= '0;
      beat_idx <= '0;
      start_col <= '0;
      beat_wr_o <= 1'b0;
    end else if (ce_i) begin
      if ((is_rd || is_wr) && !bad_access) begin
        burst_on <= 1'b1;
        burst_chop <= cmd_chop;
        burst_ap <= addr_s[AP_BIT];
        burst_bank <= ba_s;
        beat_idx <= '0;
        beat_wr_o <= is_wr;
        // writes start on a chunk boundary
        if (is_wr) begin
          start_col <= {cmd_col[COL_W-1:3], cmd_chop & cmd_col[2], 2'b00};
        end else begin
          start_col <= cmd_col;
        end
      end else if (burst_on && (ck_rise || ck_fall)) begin
        beat_idx <= beat_idx + 3'h1;
        if (last_beat) begin
          burst_on <= 1'b0;
        end
      end
    end
  end

  // beat order: nibble wrap for sequential, xor for interleaved
  always_comb begin
    if (interleave) begin
      ord = start_col[2:0] ^ beat_idx;
    end else begin
      ord = {start_col[2] ^ beat_idx[2], start_col[1:0] + beat_idx[1:0]};
    end
  end

  // two beats per link clock, eight beats span four clocks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      beat_valid_o <= 1'b0;
      beat_col_o <= '0;
      beat_bank_o <= '0;
      core_xfer_o <= 1'b0;
    end else if (ce_i) begin
      beat_valid_o <= burst_on && (ck_rise || ck_fall);
      beat_col_o <= {start_col[COL_W-1:3], ord};
      beat_bank_o <= burst_bank;
      core_xfer_o <= (is_rd || is_wr) && !bad_access; // one 8n word
    end
  end

  // ----------------------------------------------------------------
  // last access record and sticky closed-bank error
  // ----------------------------------------------------------------
  logic [31:0] last_acc;
  logic err_flag;
  logic err_clr;
  logic [BA_W-1:0] row_sel;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_acc <= '0;
    end else if (ce_i && (is_rd || is_wr)) begin
      last_acc <= {12'h000, is_wr, addr_s[BC_BIT], addr_s[AP_BIT],
                   ba_s, 3'h0, cmd_col};
    end
  end

  // set beats clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_flag <= 1'b0;
    end else if (ce_i) begin
      if (bad_access) begin
        err_flag <= 1'b1;
      end else if (err_clr) begin
        err_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave, one wait state
  // ----------------------------------------------------------------
  logic wb_req, wb_wr;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  assign err_clr = wb_wr && (wb_adr_i == REG_STATUS) && wb_dat_i[ST_ERR_BIT] &&
                   wb_sel_i[2];

  // control and row index writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_x8 <= CTRL_X8_RST;
      row_sel <= '0;
    end else if (ce_i) begin
      if (wb_wr && wb_adr_i == REG_CTRL) begin
        ctrl_x8 <= wb_dat_i[CTRL_X8_BIT];
      end
      if (wb_wr && wb_adr_i == REG_ROW) begin
        row_sel <= wb_dat_i[BA_W-1:0];
      end
    end
  end

  // unmapped reads answer zero, writes are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      wb_dat_o <= '0;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          REG_CTRL: wb_dat_o <= {31'h0, ctrl_x8};
          REG_STATUS: wb_dat_o <= {11'h000, err_flag, 3'h0, zq_seen, mr_seen,
                                   bank_open, state};
          REG_MR0: wb_dat_o <= {17'h0, mr[0]};
          REG_MR1: wb_dat_o <= {16'h0, !mr[1][DLL_EN_BIT], mr[1]};
          REG_MR2: wb_dat_o <= {17'h0, mr[2]};
          REG_MR3: wb_dat_o <= {17'h0, mr[3]};
          REG_ROW: wb_dat_o <= {1'b0, bank_row[row_sel], 13'h0, row_sel};
          REG_LAST: wb_dat_o <= last_acc;
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: dai_checker.sv
// checker: burst and power-up relations at the dram front end ports
// assumes a bind onto dai_top with its init span handed on
`timescale 1ns/1ps
`default_nettype none
module dai_checker #(
  parameter int INIT_CYCLES = 20
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset
  input wire logic reset_n_i, // device reset pin
  input wire logic term_en_o, // termination
  input wire logic [2:0] beat_bank_o, // beat bank
  input wire logic [10:0] beat_col_o, // beat column
  input wire logic beat_valid_o, // beat pulse
  input wire logic core_xfer_o, // core word pulse
  input wire logic dll_reset_o, // dll reset pulse
  input wire logic ready_o // init done
);
  logic [3:0] beat_cnt;
  logic [2:0] last_bank;
  logic [7:0] last_colhi;
  int up_cnt;
  // beats since the last core word; saturates so it never wraps
  always_ff @(posedge clk_i) begin
    if (rst_i || core_xfer_o) begin
      beat_cnt <= 4'h0;
    end else if (beat_valid_o && beat_cnt != 4'hf) begin
      beat_cnt <= beat_cnt + 4'h1;
    end
  end
  // bank and column block of the previous beat
  always_ff @(posedge clk_i) begin
    if (beat_valid_o) begin
      last_bank <= beat_bank_o;
      last_colhi <= beat_col_o[10:3];
    end
  end
  // cycles since the reset pin went high; pin level is seen early here
  always_ff @(posedge clk_i) begin
    if (rst_i || !reset_n_i) begin
      up_cnt <= 0;
    end else if (up_cnt < INIT_CYCLES) begin
      up_cnt <= up_cnt + 1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_term_off; !ready_o && !$past(ready_o) |-> !term_en_o; endproperty
  a_term_off: assert property (p_term_off) else $error("termination before init");
  property p_xfer_ready; core_xfer_o |-> $past(ready_o); endproperty
  a_xfer_ready: assert property (p_xfer_ready) else $error("access before ready");
  property p_init_time; $rose(ready_o) |-> up_cnt >= INIT_CYCLES; endproperty
  a_init_time: assert property (p_init_time) else $error("self init too short");
  property p_burst_start; core_xfer_o |-> ##[1:24] beat_valid_o; endproperty
  a_burst_start: assert property (p_burst_start) else $error("burst never began");
  property p_beat_max; beat_cnt <= 4'h8; endproperty
  a_beat_max: assert property (p_beat_max) else $error("burst longer than eight");
  property p_beat_gap; beat_valid_o |=> !beat_valid_o [*2]; endproperty
  a_beat_gap: assert property (p_beat_gap) else $error("beats too close");
  property p_bank_stable; beat_valid_o && beat_cnt != 4'h0 |-> beat_bank_o == last_bank;
  endproperty
  a_bank_stable: assert property (p_bank_stable) else $error("bank moved in burst");
  property p_col_block; beat_valid_o && beat_cnt != 4'h0 |-> beat_col_o[10:3] == last_colhi;
  endproperty
  a_col_block: assert property (p_col_block) else $error("column left its block");
  property p_dll_pulse; dll_reset_o |-> $past(ready_o) ##1 !dll_reset_o; endproperty
  a_dll_pulse: assert property (p_dll_pulse) else $error("dll reset pulse bad");
  property p_one_word; core_xfer_o |=> !core_xfer_o [*6]; endproperty
  a_one_word: assert property (p_one_word) else $error("core words too close");
endmodule
`default_nettype wire

// File: dai_ctrl_model.sv
// controller model: link clock, power-up, mode loads and commands
// assumes the bench calls its tasks; clock runs free once started, until the next power_up stops it
`timescale 1ns/1ps
`default_nettype none
module dai_ctrl_model
  import dai_pkg::*;
#(
  parameter int INIT_CYCLES = 20, // device self-init span in clk cycles
  parameter int DLLK_CK = 8 // dll lock and zq wait, short default
) (
  input wire logic clk_i, // system clock
  output logic ck_o, // link clock
  output logic cke_o, // clock enable
  output logic cs_n_o, // chip select
  output logic ras_n_o, // row strobe
  output logic cas_n_o, // column strobe
  output logic we_n_o, // write enable
  output logic [2:0] ba_o, // bank address
  output logic [14:0] addr_o, // address
  output logic odt_o, // termination request
  output logic reset_n_o // device reset
);
  logic ck_run = 1'b0;
  // phase offset keeps link edges apart from system clock edges
  initial begin
    ck_o = 1'b0;
    #7;
    forever begin
      #100;
      if (ck_run) ck_o = ~ck_o;
    end
  end
  initial begin
    {cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o} = 5'h0f;
    ba_o = 3'h0;
    addr_o = 15'h0000;
    odt_o = 1'b0; // held static through init
    reset_n_o = 1'b0;
  end
  // one command for one link period, then deselect with turned bus
  task automatic send(input logic [2:0] code, input logic [2:0] ba, input logic [14:0] a);
    @(negedge ck_o);
    cs_n_o <= 1'b0;
    {ras_n_o, cas_n_o, we_n_o} <= code;
    ba_o <= ba;
    addr_o <= a;
    @(negedge ck_o);
    cs_n_o <= 1'b1; // nop between commands
    {ras_n_o, cas_n_o, we_n_o} <= CMD_NOP;
    ba_o <= ~ba;
    addr_o <= ~a;
  endtask
  // reset and self-init waits are whole system clock cycles, rounded up; cke waits count link clocks
  task automatic power_up(input int rst_cyc);
    cke_o <= 1'b0; // low before reset release
    reset_n_o <= 1'b0;
    ck_run = 1'b0;
    repeat (rst_cyc) @(posedge clk_i);
    reset_n_o <= 1'b1;
    repeat (INIT_CYCLES + 8) @(posedge clk_i);
    ck_run = 1'b1;
    repeat (6) @(posedge ck_o);
    cke_o <= 1'b1; // stays high from here
    repeat (5) @(posedge ck_o);
  endtask
  // full register images, fixed order, then long calibration
  task automatic init_seq(input logic [14:0] mr0, input logic [14:0] mr1);
    send(CMD_MRS, MR2_SEL, 15'h0000);
    send(CMD_MRS, MR3_SEL, 15'h0000);
    send(CMD_MRS, MR1_SEL, mr1); // a0 low keeps the dll on
    send(CMD_MRS, MR0_SEL, mr0); // a8 high resets the dll
    send(CMD_ZQ, 3'h0, 15'h0400);
    repeat (DLLK_CK) @(posedge ck_o);
  endtask
endmodule
`default_nettype wire

// File: tb.sv
// testbench: power-up, mode loads, bursts and registers of dai_top
// assumes the controller model drives every link pin
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dai_pkg::*;
  localparam int INIT_N = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic ck, cke, cs_n, ras_n, cas_n, we_n, odt, reset_n;
  logic [2:0] ba, beat_bank;
  logic [14:0] addr;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0, dat_o, rdat;
  logic term_en, beat_valid, beat_wr, core_xfer, dll_reset, ready, ack;
  logic [10:0] beat_col;
  logic [11:0] beats[$];
  int xfers = 0, dll_pulses = 0, errors = 0, comparisons = 0;
  dai_top #(.INIT_CYCLES(INIT_N)) u_dai_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .ck_i(ck), .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n),
    .ba_i(ba), .addr_i(addr), .odt_i(odt), .reset_n_i(reset_n), .term_en_o(term_en),
    .beat_bank_o(beat_bank), .beat_col_o(beat_col), .beat_valid_o(beat_valid),
    .beat_wr_o(beat_wr), .core_xfer_o(core_xfer), .dll_reset_o(dll_reset), .ready_o(ready),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack));
  dai_ctrl_model #(.INIT_CYCLES(INIT_N)) u_dai_ctrl_model (.clk_i(clk_i), .ck_o(ck),
    .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba),
    .addr_o(addr), .odt_o(odt), .reset_n_o(reset_n));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // beats with their direction, core words and dll pulses
  always @(posedge clk_i) begin
    if (beat_valid === 1'b1) beats.push_back({beat_wr, beat_col});
    if (core_xfer === 1'b1) xfers++;
    if (dll_reset === 1'b1) dll_pulses++;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // classic single cycle; waits for ack however long it takes
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string what);
    wb(1'b0, a, 32'h0);
    check(what, exp, rdat);
  endtask
  // one access to bank 5; beat i is base or the i-th nibble of ord
  task automatic burst(input logic [2:0] code, input logic [14:0] a, input logic [11:0] base,
                       input logic [31:0] ord, input int n);
    int k;
    int x0;
    beats.delete();
    x0 = xfers;
    k = 0;
    u_dai_ctrl_model.send(code, 3'h5, a);
    while (beats.size() < n && k < 200) begin
      @(posedge clk_i);
      k++;
    end
    repeat (40) @(posedge clk_i);
    check("beat count", n, beats.size());
    check("core words", x0 + (n != 0), xfers);
    for (int i = 0; i < n; i++) begin
      check("beat", base | ord[28 - 4 * i +: 3], beats[i]);
    end
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic give_verdict();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog sized well above two power-ups and the bursts
  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("ready in reset", 1'b0, ready);
    u_dai_ctrl_model.power_up(8000);
    check("termination", 1'b0, term_en);
    check("ready", 1'b1, ready);
    u_dai_ctrl_model.init_seq(15'h0101, 15'h0004);
    rd(REG_STATUS, 32'h0001f008, "status after init");
    rd(REG_MR1, 32'h00008004, "mr1 image");
    rd(REG_MR0, 32'h00000101, "mr0 image");
    check("dll reset pulses", 1, dll_pulses);
    done("init");
    u_dai_ctrl_model.send(CMD_ACT, 3'h5, 15'h1abc); // bank opened first
    wb(1'b1, REG_ROW, 32'h5);
    rd(REG_ROW, 32'h1abc0005, "row of bank");
    rd(REG_STATUS, 32'h0001f208, "open banks");
    burst(CMD_RD, 15'h1805, 12'h400, 32'h56741230, 8);
    rd(REG_LAST, 32'h00054405, "last command");
    burst(CMD_RD, 15'h0006, 12'h000, 32'h67450000, 4);
    burst(CMD_WR, 15'h1003, 12'h800, 32'h01234567, 8);
    done("bursts");
    wb(1'b1, REG_CTRL, 32'h1);
    burst(CMD_RD, 15'h1805, 12'h000, 32'h56741230, 8);
    burst(CMD_RD, 15'h1401, 12'h000, 32'h12305674, 8);
    burst(CMD_RD, 15'h1000, 12'h000, 32'h0, 0);
    rd(REG_STATUS, 32'h0011f008, "closed bank error");
    wb(1'b1, REG_STATUS, 32'h00100000);
    rd(REG_STATUS, 32'h0001f008, "error cleared");
    done("precharge");
    u_dai_ctrl_model.power_up(4);
    check("ready after warm reset", 1'b1, ready);
    u_dai_ctrl_model.init_seq(15'h0101, 15'h0004);
    burst(CMD_RD, 15'h1000, 12'h000, 32'h0, 0); // banks still closed after reset
    check("dll reset pulses", 2, dll_pulses);
    done("warm reset");
    give_verdict();
  end
endmodule
bind dai_top dai_checker #(.INIT_CYCLES(INIT_CYCLES)) u_dai_checker (.clk_i(clk_i),
  .rst_i(rst_i), .reset_n_i(reset_n_i), .term_en_o(term_en_o), .beat_bank_o(beat_bank_o),
  .beat_col_o(beat_col_o), .beat_valid_o(beat_valid_o), .core_xfer_o(core_xfer_o),
  .dll_reset_o(dll_reset_o), .ready_o(ready_o));
`default_nettype wire
